// ===== verilog/mms_host.sv
// Purpose: Host end: APB-driven two-wire bus master with module select
// Assumes: One module on the link; APB on clk
// Notes:   One command at a time; commands while busy are dropped
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "mms_map.svh"
module mms_host #(
   parameter int SETUP_CYC = `MMS_SETUP_CYC
) (
   input  wire logic        clk,      // System clock
   input  wire logic        rst,      // Sync reset, high
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB enable
   input  wire logic        pwrite,   // APB direction
   input  wire logic [7:0]  paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error, unmapped
   output logic             irq,      // Level interrupt
   mms_link_if.host         link      // Two-wire link and select
);
   import mms_pkg::*;

   mms_host_state_t q, n;
   logic            s_scl, s_sda, wr_acc, hold_pt;
   logic [1:0]      ev, clr;
   mms_byte_t       b, b_nx;

   mms_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({link.scl, link.sda}),
      .q   ({s_scl, s_sda})
   );

   // Byte sequence of each command
   function automatic mms_byte_t byte_of(input mms_op_t op, input logic [1:0] i,
                                         input logic [7:0] a, input logic [7:0] d);
      byte_of = '0;
      case (op)
         MMS_OP_WR: byte_of.val = (i == 2'h0) ? {`MMS_DEV_ADDR, 1'b0} : ((i == 2'h1) ? a : d);
         MMS_OP_RAND: begin
            byte_of.val     = (i == 2'h0) ? {`MMS_DEV_ADDR, 1'b0} : ((i == 2'h1) ? a : {`MMS_DEV_ADDR, 1'b1});
            byte_of.restart = (i == 2'h2);
            byte_of.rd      = (i == 2'h3);
         end
         default: begin
            byte_of.val = {`MMS_DEV_ADDR, 1'b1};
            byte_of.rd  = (i == 2'h1);
         end
      endcase
      byte_of.last = (op == MMS_OP_WR && i == 2'h2) || (op == MMS_OP_RAND && i == 2'h3) ||
                     (op != MMS_OP_WR && op != MMS_OP_RAND && i == 2'h1);
   endfunction

   always_comb begin
      n       = q;
      ev      = 2'h0;
      clr     = 2'h0;
      wr_acc  = psel & penable & q.pready & pwrite;
      hold_pt = (q.cnt == `MMS_DAT_HOLD_CYC);
      b       = byte_of(q.op, q.byte_idx, q.mem_addr, q.wdata);
      b_nx    = byte_of(q.op, q.byte_idx + 2'h1, q.mem_addr, q.wdata);
      n.cnt   = q.cnt + 32'h1;

      // APB: setup cycle prepares the answer, access cycle completes
      n.pready  = psel & ~penable;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0;
      if (psel && !penable) begin
         case (paddr)
            `MMS_REG_CMD, `MMS_REG_IRQ_CLR: n.prdata = 32'h0;
            `MMS_REG_STAT: n.prdata = {16'h0, q.rdata, 6'h0, q.nack, q.busy};
            `MMS_REG_IRQ_STAT: n.prdata = {30'h0, q.irq_stat};
            `MMS_REG_IRQ_EN: n.prdata = {30'h0, q.irq_en};
            default: n.pslverr = 1'b1;
         endcase
      end
      if (wr_acc && paddr == `MMS_REG_IRQ_EN) begin
         n.irq_en = pwdata[1:0];
      end
      if (wr_acc && paddr == `MMS_REG_IRQ_CLR) begin
         clr = pwdata[1:0];
      end

      case (q.st)
         MMS_H_IDLE: begin
            if (wr_acc && paddr == `MMS_REG_CMD && pwdata[`MMS_CMD_GO]) begin
               n.op       = mms_op_t'(pwdata[`MMS_CMD_OP_LO +: 2]);
               n.mem_addr = pwdata[`MMS_CMD_ADDR_LO +: 8];
               n.wdata    = pwdata[`MMS_CMD_DATA_LO +: 8];
               n.busy     = (pwdata[`MMS_CMD_OP_LO +: 2] != MMS_OP_NONE);
               n.sel_oe   = n.busy; // R07
               n.nack     = 1'b0;
               n.cnt      = 32'h0;
               n.st       = n.busy ? MMS_H_SETUP : MMS_H_IDLE;
            end
         end
         MMS_H_SETUP: begin
            if (q.cnt >= SETUP_CYC - 1) begin // R04
               n.cnt      = 32'h0;
               n.ph       = 2'h0;
               n.byte_idx = 2'h0;
               n.st       = MMS_H_START;
            end
         end
         MMS_H_START, MMS_H_STOP: begin
            if (q.ph == 2'h0) begin
               n.scl_oe = 1'b1;
               if (hold_pt) begin
                  n.sda_oe = (q.st == MMS_H_STOP);
               end
               if (q.cnt >= `MMS_LOW_CYC - 1) begin // R09
                  n.scl_oe = 1'b0;
                  n.cnt    = 32'h0;
                  n.ph     = 2'h1;
               end
            end else if (!s_scl) begin
               n.cnt = 32'h0; // R11
            end else if (q.cnt >= `MMS_HIGH_CYC - 1) begin
               n.cnt = 32'h0;
               if (q.st == MMS_H_STOP) begin
                  n.sda_oe = 1'b0;
                  n.st     = MMS_H_GAP;
               end else if (q.ph == 2'h1) begin
                  n.sda_oe = 1'b1;
                  n.ph     = 2'h2;
               end else begin
                  n.scl_oe  = 1'b1;
                  n.sh      = b.val;
                  n.bit_idx = 4'h0;
                  n.ph      = 2'h0;
                  n.st      = MMS_H_BIT;
               end
            end
         end
         MMS_H_BIT: begin
            if (q.ph == 2'h0) begin
               if (hold_pt) begin
                  n.sda_oe = ~b.rd & (q.bit_idx != 4'h8) & ~q.sh[7];
               end
               if (q.cnt >= `MMS_LOW_CYC - 1) begin // R09
                  n.scl_oe = 1'b0;
                  n.cnt    = 32'h0;
                  n.ph     = 2'h1;
               end
            end else if (!s_scl) begin
               n.cnt = 32'h0; // R11
            end else if (q.cnt >= `MMS_HIGH_CYC - 1) begin
               n.cnt     = 32'h0;
               n.ph      = 2'h0;
               n.scl_oe  = 1'b1;
               n.bit_idx = q.bit_idx + 4'h1;
               if (q.bit_idx != 4'h8) begin
                  n.sh = {q.sh[6:0], s_sda};
               end else begin
                  // Reads are single bytes: no ack, then stop
                  if (!b.rd && s_sda) begin
                     n.nack = 1'b1;
                  end
                  if (b.rd) begin
                     n.rdata = q.sh;
                  end
                  if (b.last || (!b.rd && s_sda)) begin
                     n.st = MMS_H_STOP; // R16
                  end else begin
                     n.byte_idx = q.byte_idx + 2'h1;
                     n.sh       = b_nx.val;
                     n.bit_idx  = 4'h0;
                     n.st       = b_nx.restart ? MMS_H_START : MMS_H_BIT;
                  end
               end
            end
         end
         MMS_H_GAP: begin
            // Select stays put through the hold, bus idles past the free time
            if (q.cnt >= `MMS_HOLD_CYC - 1) begin
               n.sel_oe = 1'b0; // R05
            end
            if (q.cnt >= `MMS_IDLE_CYC - 1) begin // R10
               n.busy = 1'b0;
               ev     = {q.nack, 1'b1};
               n.st   = MMS_H_IDLE;
            end
         end
         default: n.st = MMS_H_IDLE;
      endcase

      n.irq_stat = (q.irq_stat & ~clr) | ev;
      n.irq      = |(q.irq_stat & q.irq_en);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign link.host_scl_o   = 1'b0;
   assign link.host_sda_o   = 1'b0;
   assign link.host_scl_oe  = q.scl_oe;
   assign link.host_sda_oe  = q.sda_oe;
   assign link.host_sel_n_o = 1'b0;
   assign link.host_sel_oe  = q.sel_oe;
   assign prdata            = q.prdata;
   assign pready            = q.pready;
   assign pslverr           = q.pslverr;
   assign irq               = q.irq;
endmodule
`default_nettype wire

// ===== verilog/mms_map.svh
// Purpose: Offsets, fields and timing counts of the management serial link
// Assumes: 50 MHz system clock on both ends
// Notes:   Times are kept in their own unit; cycle counts are derived from them
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH

`define MMS_CLK_NS        20
`define MMS_DEV_ADDR      7'h50
`define MMS_ID_OFS        8'h80
`define MMS_MAP_ID        8'h3C
`define MMS_RATE_KHZ      400
`define MMS_LOW_NS        1200
`define MMS_HIGH_NS       1100
`define MMS_IDLE_NS       20800
`define MMS_HOLD_US       10
`define MMS_SETUP_MS      2
`define MMS_STRETCH_US    500
`define MMS_DAT_HOLD_NS   300
`define MMS_BLINK_MS      250

`define MMS_PERIOD_CYC    ((1000000 / `MMS_RATE_KHZ + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_HIGH_CYC      ((`MMS_HIGH_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_LOW_MIN_CYC   ((`MMS_LOW_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_LOW_CYC       ((`MMS_PERIOD_CYC - `MMS_HIGH_CYC) > `MMS_LOW_MIN_CYC ? \
                           (`MMS_PERIOD_CYC - `MMS_HIGH_CYC) : `MMS_LOW_MIN_CYC)
`define MMS_IDLE_CYC      ((`MMS_IDLE_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_HOLD_CYC      ((`MMS_HOLD_US * 1000 + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_SETUP_CYC     ((`MMS_SETUP_MS * 1000000 + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_STRETCH_CYC   ((`MMS_STRETCH_US * 1000) / `MMS_CLK_NS)
`define MMS_DAT_HOLD_CYC  ((`MMS_DAT_HOLD_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_BLINK_CYC     ((`MMS_BLINK_MS * 1000000) / `MMS_CLK_NS)

`define MMS_REG_CMD       8'h00
`define MMS_REG_STAT      8'h04
`define MMS_REG_IRQ_STAT  8'h08
`define MMS_REG_IRQ_CLR   8'h0C
`define MMS_REG_IRQ_EN    8'h10
`define MMS_CMD_GO        0
`define MMS_CMD_OP_LO     1
`define MMS_CMD_ADDR_LO   8
`define MMS_CMD_DATA_LO   16
`define MMS_STAT_BUSY     0
`define MMS_STAT_NACK     1
`define MMS_STAT_DATA_LO  8
`define MMS_IRQ_DONE      0
`define MMS_IRQ_NACK      1

`endif

// ===== verilog/mms_pkg.sv
// Purpose: Types shared by both ends of the management serial link
// Assumes: mms_map.svh holds all numbers
// Notes:   State of each end is one packed struct
package mms_pkg;
   typedef enum logic [2:0] {
      MMS_D_IDLE = 3'h0, MMS_D_ADDR = 3'h1, MMS_D_AACK = 3'h2, MMS_D_WR = 3'h3,
      MMS_D_WACK = 3'h4, MMS_D_RD = 3'h5, MMS_D_RACK = 3'h6, MMS_D_SKIP = 3'h7
   } mms_dev_st_t;

   typedef enum logic [2:0] {
      MMS_H_IDLE = 3'h0, MMS_H_SETUP = 3'h1, MMS_H_START = 3'h2,
      MMS_H_BIT = 3'h3, MMS_H_STOP = 3'h4, MMS_H_GAP = 3'h5
   } mms_host_st_t;

   typedef enum logic [1:0] {
      MMS_OP_WR = 2'h0, MMS_OP_RAND = 2'h1, MMS_OP_CUR = 2'h2, MMS_OP_NONE = 2'h3
   } mms_op_t;

   typedef struct packed {
      logic       rd;
      logic       restart;
      logic       last;
      logic [7:0] val;
   } mms_byte_t;

   typedef struct packed {
      mms_dev_st_t       st;
      logic [3:0]        bits;
      logic [7:0]        sh;
      logic [7:0]        addr;
      logic              rw;
      logic              first;
      logic              sda_oe;
      logic              scl_oe;
      logic [31:0]       str_cnt;
      logic              scl_p;
      logic              sda_p;
      logic [31:0]       blink_cnt;
      logic              blink;
      logic              led_g;
      logic              led_r;
      logic [255:0][7:0] mem;
   } mms_dev_state_t;

   typedef struct packed {
      mms_host_st_t st;
      mms_op_t      op;
      logic [1:0]   ph;
      logic [31:0]  cnt;
      logic [3:0]   bit_idx;
      logic [1:0]   byte_idx;
      logic [7:0]   sh;
      logic         scl_oe;
      logic         sda_oe;
      logic         sel_oe;
      logic         busy;
      logic         nack;
      logic [7:0]   rdata;
      logic [7:0]   mem_addr;
      logic [7:0]   wdata;
      logic [1:0]   irq_stat;
      logic [1:0]   irq_en;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic         irq;
   } mms_host_state_t;
endpackage

// ===== verilog/mms_link_if.sv
// Purpose: Two-wire management link plus module select between host and module
// Assumes: Open-drain clock and data with pull-ups
// Notes:   Line levels are resolved here from the drive enables
`timescale 1ns/100ps
`default_nettype none
interface mms_link_if;
   logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
   logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
   logic host_sel_n_o, host_sel_oe;
   logic scl, sda, module_select_n;

   // Pulled high when nobody drives low
   assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   // Select pulled inactive inside the module
   assign module_select_n = host_sel_oe ? host_sel_n_o : 1'b1; // R07

   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                 output host_sel_n_o, host_sel_oe, input scl, sda);
   modport device (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
                   input scl, sda, module_select_n);
endinterface
`default_nettype wire

// ===== verilog/mms_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   Only the second stage is visible to other logic
`timescale 1ns/100ps
`default_nettype none
module mms_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         clk,  // System clock
   input  wire logic         rst,  // Sync reset, high
   input  wire logic [W-1:0] d,    // Asynchronous levels
   output logic      [W-1:0] q     // Synchronised levels
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/mms_dev.sv
// Purpose: Module end: two-wire management slave, select gate and status lamp
// Assumes: Host is the only bus master; high_power and temp_alarm are on clk
// Notes:   Memory cleared at reset; byte 128 is read-only
// Summary of operation
// [R01] High power mode lights lamp green
// [R02] Low power mode lights lamp red
// [R03] Temperature alarm blinks green and red
// [R04] Host asserts select 2 ms before traffic
// [R05] Host holds select 10 us after end
// [R06] Answer address 1010000, last bit direction
// [R07] Select pulled high inside, host drives low
// [R08] Ignore bus while select is high
// [R09] Host clock at most 400 kHz
// [R10] Host waits 20.8 us after stop
// [R11] Stretch clock never beyond 500 us
// [R12] Byte 128 returns memory map identifier
// [R13] Acknowledge matching address while selected
// [R14] Direction high reads, low writes
// [R15] Address counter increments, wraps within page
// [R16] Host acks reads, stops after last; host here never acks, each read is one byte then stop
// [R17] Mismatch: stay released until next start
`timescale 1ns/100ps
`default_nettype none
`include "mms_map.svh"
module mms_dev #(
   parameter logic [7:0] MAP_ID          = `MMS_MAP_ID,      // Value arbitrary
   parameter int         STRETCH_CYC     = 8,
   parameter int         STRETCH_MAX_CYC = `MMS_STRETCH_CYC,
   parameter int         BLINK_CYC       = `MMS_BLINK_CYC
) (
   input  wire logic clk,         // System clock
   input  wire logic rst,         // Sync reset, high
   mms_link_if.device link,       // Two-wire link and select
   input  wire logic high_power,  // High power mode level
   input  wire logic temp_alarm,  // Temperature alarm level
   output logic      led_green,   // Green lamp
   output logic      led_red      // Red lamp
);
   import mms_pkg::*;

   mms_dev_state_t q, n;
   logic           s_scl, s_sda, s_sel_n;
   logic           rise, fall, start, stop;
   logic [7:0]     rd_byte;

   // Pins come from outside the clock domain
   mms_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({link.scl, link.sda, link.module_select_n}),
      .q   ({s_scl, s_sda, s_sel_n})
   );

   // Wrap inside the current 128-byte page
   function automatic logic [7:0] next_addr(input logic [7:0] a);
      next_addr = {a[7], a[6:0] + 7'h01};
   endfunction

   always_comb begin
      n       = q;
      rise    = s_scl & ~q.scl_p;
      fall    = ~s_scl & q.scl_p;
      start   = q.scl_p & s_scl & q.sda_p & ~s_sda;
      stop    = q.scl_p & s_scl & ~q.sda_p & s_sda;
      n.scl_p = s_scl;
      n.sda_p = s_sda;
      rd_byte = (q.addr == `MMS_ID_OFS) ? MAP_ID : q.mem[q.addr]; // R12

      // Stretch ends at the fetch time, and never past the ceiling
      if (q.scl_oe) begin
         n.str_cnt = q.str_cnt + 32'h1;
         if (n.str_cnt >= STRETCH_CYC || n.str_cnt >= STRETCH_MAX_CYC) begin
            n.scl_oe = 1'b0; // R11
         end
      end

      // Data taken on rising, launched after falling edges
      case (q.st)
         MMS_D_ADDR, MMS_D_WR: begin
            if (rise) begin
               n.sh   = {q.sh[6:0], s_sda};
               n.bits = q.bits + 4'h1;
            end
            // Eighth fall: acknowledge or step aside
            if (fall && q.bits == 4'h8) begin
               if (q.st == MMS_D_ADDR) begin
                  if (q.sh[7:1] == `MMS_DEV_ADDR && !s_sel_n) begin // R06
                     n.sda_oe = 1'b1; // R13
                     n.rw     = q.sh[0]; // R14
                     n.st     = MMS_D_AACK;
                  end else begin
                     n.st = MMS_D_SKIP; // R17
                  end
               end else begin
                  if (q.first) begin
                     n.addr  = q.sh;
                     n.first = 1'b0;
                  end else begin
                     // Identifier byte is read-only
                     if (q.addr != `MMS_ID_OFS) begin
                        n.mem[q.addr] = q.sh;
                     end
                     n.addr = next_addr(q.addr); // R15
                  end
                  n.sda_oe = 1'b1;
                  n.st     = MMS_D_WACK;
               end
            end
         end
         MMS_D_AACK: begin
            if (fall) begin
               n.bits = 4'h0;
               // Read: brief stretch while the byte is fetched
               if (q.rw) begin
                  n.sh      = rd_byte;
                  n.sda_oe  = ~rd_byte[7];
                  n.scl_oe  = 1'b1; // R11
                  n.str_cnt = 32'h0;
                  n.st      = MMS_D_RD;
               end else begin
                  n.sda_oe = 1'b0;
                  n.first  = 1'b1;
                  n.st     = MMS_D_WR;
               end
            end
         end
         MMS_D_WACK: begin
            if (fall) begin
               n.sda_oe = 1'b0;
               n.bits   = 4'h0;
               n.st     = MMS_D_WR;
            end
         end
         MMS_D_RD: begin
            if (rise) begin
               n.bits = q.bits + 4'h1;
            end
            // Next bit goes out just after each fall
            if (fall) begin
               if (q.bits == 4'h8) begin
                  n.sda_oe = 1'b0;
                  n.addr   = next_addr(q.addr); // R15
                  n.st     = MMS_D_RACK;
               end else begin
                  n.sh     = {q.sh[6:0], 1'b0};
                  n.sda_oe = ~q.sh[6];
               end
            end
         end
         MMS_D_RACK: begin
            // Host ack means one more byte; no ack ends the read
            if (rise) begin
               n.st = s_sda ? MMS_D_SKIP : MMS_D_AACK;
            end
         end
         default: begin
         end
      endcase

      // Start restarts the frame from any state
      if (start) begin
         n.bits   = 4'h0;
         n.sda_oe = 1'b0;
         n.st     = s_sel_n ? MMS_D_SKIP : MMS_D_ADDR; // R08
      end
      // Deselect aborts at once and lets both lines go
      if (stop || (s_sel_n && q.st != MMS_D_IDLE && q.st != MMS_D_SKIP)) begin
         n.sda_oe = 1'b0; // R08
         n.scl_oe = 1'b0;
         n.st     = stop ? MMS_D_IDLE : MMS_D_SKIP;
      end

      // Lamp lags its inputs by one cycle
      if (temp_alarm) begin
         n.blink_cnt = q.blink_cnt + 32'h1;
         if (q.blink_cnt >= BLINK_CYC - 1) begin
            n.blink_cnt = 32'h0;
            n.blink     = ~q.blink;
         end
         n.led_g = q.blink; // R03
         n.led_r = ~q.blink; // R03
      end else begin
         n.blink_cnt = 32'h0;
         n.blink     = 1'b0;
         n.led_g     = high_power; // R01
         n.led_r     = ~high_power; // R02
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         // Lines idle high, so no false edge after reset
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign link.dev_scl_o  = 1'b0;
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_scl_oe = q.scl_oe;
   assign link.dev_sda_oe = q.sda_oe;
   assign led_green       = q.led_g;
   assign led_red         = q.led_r;
endmodule
`default_nettype wire

// ===== dv/mms_link_chk.sv
// Purpose: Wire-level timing and select checks on the link
// Assumes: Line levels already resolved by the interface
// Notes:   Counters are wide enough for any run length
`timescale 1ns/100ps
`default_nettype none
module mms_link_chk #(
   parameter int SETUP_CYC = 200
) (
   input wire logic clk,              // System clock
   input wire logic rst,              // Sync reset
   input wire logic scl,              // Clock line
   input wire logic sda,              // Data line
   input wire logic module_select_n,  // Select at module
   input wire logic host_sel_oe,      // Host select drive
   input wire logic dev_scl_oe,       // Stretch drive
   input wire logic dev_sda_oe        // Device data drive
);
   logic        sda_q;
   logic        start;
   logic        stop;
   logic [31:0] sel_n, gap_n, lo_n, hi_n, str_n;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign start = scl & sda_q & ~sda;
   assign stop  = scl & ~sda_q & sda;
   always_ff @(posedge clk) begin
      sda_q <= rst | sda;
      sel_n <= (rst | ~host_sel_oe) ? 32'h0 : sel_n + 32'h1;
      // Big at reset so the first start counts as after a long idle
      // One at the edge after stop: the detector lags a cycle
      gap_n <= rst ? 32'h000F_FFFF : (stop ? 32'h1 : gap_n + 32'h1);
      lo_n  <= (rst | scl) ? 32'h0 : lo_n + 32'h1;
      hi_n  <= (rst | ~scl) ? 32'h0 : hi_n + 32'h1;
      str_n <= (rst | ~dev_scl_oe) ? 32'h0 : str_n + 32'h1;
   end
   chk_sel_setup: assert property (start |-> sel_n >= SETUP_CYC)
      else $error("start before select setup time");
   chk_sel_hold: assert property ($fell(host_sel_oe) |-> gap_n >= 500 && scl && sda)
      else $error("select dropped too soon after stop");
   chk_bus_gap: assert property (start |-> gap_n >= 1040)
      else $error("start too soon after stop");
   chk_low_width: assert property ($rose(scl) |-> lo_n >= 60)
      else $error("clock low phase too short");
   chk_high_width: assert property ($fell(scl) |-> hi_n >= 55)
      else $error("clock high phase too short");
   chk_desel_quiet: assert property (module_select_n [*5] |-> !dev_sda_oe && !dev_scl_oe)
      else $error("device drives link while deselected");
   chk_stretch_max: assert property (str_n <= 25000)
      else $error("clock stretched too long");
   chk_data_edge: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device data changed while clock high");
   cover property (start);
   cover property (dev_scl_oe [*8]);
   cover property ($rose(dev_sda_oe) && !module_select_n);
endmodule
`default_nettype wire

// ===== dv/module_mgmt_serial_slave_test.sv
// Purpose: Host and module joined; APB commands run real link traffic
// Assumes: Short setup and blink counts for simulation
// Notes:   Link data are judged through the host status register
`timescale 1ns/100ps
`default_nettype none
`include "mms_map.svh"
module module_mgmt_serial_slave_test;
   import mms_pkg::*;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic        pready, pslverr, irq, led_green, led_red, high_power = 0, temp_alarm = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          num_errors = 0, check_count = 0, g;
   always #10 clk = ~clk;
   mms_link_if mms_link_if_inst ();
   mms_host #(.SETUP_CYC(200)) mms_host_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(mms_link_if_inst));
   mms_dev #(.BLINK_CYC(16)) mms_dev_inst (.clk(clk), .rst(rst), .link(mms_link_if_inst),
      .high_power(high_power), .temp_alarm(temp_alarm), .led_green(led_green), .led_red(led_red));
   mms_link_chk #(.SETUP_CYC(200)) mms_link_chk_inst (.clk(clk), .rst(rst), .scl(mms_link_if_inst.scl),
      .sda(mms_link_if_inst.sda), .module_select_n(mms_link_if_inst.module_select_n),
      .host_sel_oe(mms_link_if_inst.host_sel_oe), .dev_scl_oe(mms_link_if_inst.dev_scl_oe),
      .dev_sda_oe(mms_link_if_inst.dev_sda_oe));
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Pready seen high at this edge closes the access
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         check("pready", 32'h1, 32'h0);
         report_and_stop;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task xfer(input mms_op_t op, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      apb(1'b1, `MMS_REG_CMD, {8'h00, d, a, 5'h00, op, 1'b1});
      do begin
         apb(1'b0, `MMS_REG_STAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 5000);
      if (n >= 5000) begin
         check("busy", 32'h0, 32'h1);
         report_and_stop;
      end
   endtask
   task stat_is(input logic [7:0] e);
      apb(1'b0, `MMS_REG_STAT, 32'h0);
      check("stat", {16'h0000, e, 8'h00}, rd & 32'h0000_FF03);
   endtask
   task t_regs;
      apb(1'b0, `MMS_REG_IRQ_EN, 32'h0);
      check("irq_en reset", 32'h0, rd);
      apb(1'b1, `MMS_REG_IRQ_EN, 32'h3);
      apb(1'b0, `MMS_REG_IRQ_EN, 32'h0);
      check("irq_en", 32'h3, rd);
      apb(1'b1, `MMS_REG_IRQ_EN, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", 32'h1, 32'(err));
      apb(1'b1, `MMS_REG_CMD, 32'h0000_0007);
      stat_is(8'h00);
   endtask
   task t_lamp;
      high_power <= 1'b1;
      repeat (3) @(posedge clk);
      check("lamp hi", 32'h2, {30'h0, led_green, led_red});
      high_power <= 1'b0;
      repeat (3) @(posedge clk);
      check("lamp lo", 32'h1, {30'h0, led_green, led_red});
      temp_alarm <= 1'b1;
      repeat (3) @(posedge clk);
      g = 0;
      repeat (40) begin
         @(posedge clk);
         g += int'(led_green === 1'b1 && led_red === 1'b0);
         if (led_green === led_red) check("blink pair", 32'h1, 32'h0);
      end
      check("blink mix", 32'h1, 32'(g > 0 && g < 40));
      temp_alarm <= 1'b0;
   endtask
   task t_link;
      xfer(MMS_OP_WR, 8'h00, 8'h5A);
      check("irq masked", 32'h0, 32'(irq));
      apb(1'b0, `MMS_REG_IRQ_STAT, 32'h0);
      check("irq_stat", 32'h1, rd);
      apb(1'b1, `MMS_REG_IRQ_EN, 32'h3);
      repeat (2) @(posedge clk);
      check("irq on", 32'h1, 32'(irq));
      apb(1'b1, `MMS_REG_IRQ_CLR, 32'h3);
      repeat (2) @(posedge clk);
      check("irq off", 32'h0, 32'(irq));
      xfer(MMS_OP_RAND, 8'h00, 8'h00);
      stat_is(8'h5A);
      xfer(MMS_OP_WR, 8'h7F, 8'hC3);
      xfer(MMS_OP_CUR, 8'h00, 8'h00);
      stat_is(8'h5A);
      xfer(MMS_OP_CUR, 8'h00, 8'h00);
      stat_is(8'h00);
      xfer(MMS_OP_RAND, 8'h80, 8'h00);
      stat_is(8'h3C);
      xfer(MMS_OP_RAND, 8'h7F, 8'h00);
      stat_is(8'hC3);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_lamp;
      t_link;
      report_and_stop;
   end
endmodule
`default_nettype wire
